// ### design/serial_port.sv
// Purpose: Async serial port with infrared mode, Avalon-MM registers
// Assumes: Single core clock; divisor of zero stops the baud clock
// Notes: Pins pass a three-flop filter before use
//
// Operation
// - Frame: start bit, data LSB first, optional parity, 1/1.5/2 stop bits.
// - Five to eight data bits; parity none, odd or even.
// - Parity bit follows last data bit; receiver checks it.
// - Each bit lasts sixteen baud clocks except the half stop bit.
// - Bits equal in length; half stop bit lasts half a bit.
// - Receiver samples start near middle, then every sixteen baud clocks.
// - Baud clock is core clock divided by high and low divisor bytes.
// - Active-low baud reference output for equipment needing timing.
// - Separate sixteen-byte transmit and receive FIFOs.
// - Modem lines RTS, CTS, DTR and DSR for flow control.
// - Drive break on serial output outside infrared mode and detect break on input.
// - Infrared frames: eight data bits, no parity, one stop bit.
// - Modem control bit six enables infrared; no effect without support.
// - Infrared mode uses dedicated infrared pins instead of serial pins.
// - Infrared zero is a three-sixteenths bit pulse; one sends nothing.
// - Low-power reception accepts short pulses using the low-power divisor.
// - Fast enough serial clock with valid divisor detects shortest pulses.
// - Slower clocks need given low-power divisors for given pulse widths.
// - After configuration, eight cycles pass before data moves.
// - Timeout when receive FIFO idles four character times while non-empty.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module serial_port
    import uart_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire avs_req_t i_avs,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_serial_in,
    output logic o_serial_out,
    input wire logic i_ir_in,
    output logic o_ir_out_n,
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    output logic o_rts_n,
    output logic o_dtr_n,
    output logic o_baud_out_n
);
    logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic wait_q, wait_d, take, wr, rd, busy, ir_on, rx_in;
    logic [7:0] rdata_q, rdata_d, div_lo_q, div_lo_d, div_hi_q, div_hi_d;
    logic [7:0] lc_q, lc_d, mc_q, mc_d, lpl_q, lpl_d, lph_q, lph_d;
    logic [7:0] err_q, err_d, ls_val;
    logic [3:0] settle_q, settle_d;
    logic rtsn_q, rtsn_d, dtrn_q, dtrn_d;
    frame_fmt_t fmt;
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [4:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic tx_push, tx_pop, rx_push, rx_pop, tx_empty, rx_empty, tx_full, rx_full;
    logic [15:0] bcnt_q, bcnt_d, lpcnt_q, lpcnt_d;
    logic tick_q, tick_d, lptick_q, lptick_d, baudn_q;
    logic [5:0] hold_q, hold_d;
    frame_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
    logic [5:0] tx_tick_q, tx_tick_d, rx_tick_q, rx_tick_d;
    logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
    logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
    logic tx_x_q, tx_x_d, rx_x_q, rx_x_d, rx_zero_q, rx_zero_d, perr_q, perr_d;
    logic tx_lvl, tx_go, tx_end, sout_q, sout_d, irn_q, irn_d, rx_samp;
    logic ovr_set, per_set, fer_set, brk_set, tmo_set;
    logic [9:0] tmo_q, tmo_d;

    assign ir_on = IR_BUILD & mc_q[MC_IR];
    assign fmt = make_fmt(lc_q, ir_on);
    assign busy = settle_q != 4'h0;
    assign take = (i_avs.read | i_avs.write) & ~wait_q;
    assign wr = take & i_avs.write & i_avs.byteenable[0];
    assign rd = take & i_avs.read;
    assign tx_empty = tx_wp_q == tx_rp_q;
    assign rx_empty = rx_wp_q == rx_rp_q;
    assign tx_full = fifo_full(tx_wp_q, tx_rp_q);
    assign rx_full = fifo_full(rx_wp_q, rx_rp_q);
    assign tx_push = wr && i_avs.address == OFS_DATA && !tx_full;
    assign rx_pop = rd && i_avs.address == OFS_DATA && !rx_empty;
    assign o_avs_readdata = {24'h000000, rdata_q};
    assign o_avs_waitrequest = wait_q;
    assign o_serial_out = sout_q;
    assign o_ir_out_n = irn_q;
    assign o_rts_n = rtsn_q;
    assign o_dtr_n = dtrn_q;
    assign o_baud_out_n = baudn_q;

    // A change counts once the last two stages agree
    always_comb begin
        filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= 4'hF;
            s2_q <= 4'hF;
            s3_q <= 4'hF;
            filt_q <= 4'hF;
        end else begin
            s1_q <= {i_dsr_n, i_cts_n, i_ir_in, i_serial_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    always_comb begin
        ls_val = err_q;
        ls_val[0] = ~rx_empty;
        ls_val[5] = tx_empty;
        ls_val[6] = tx_empty && tx_st_q == ST_IDLE;
        wait_d = ~((i_avs.read | i_avs.write) & wait_q);
        rdata_d = rdata_q;
        if (i_avs.read && wait_q) begin
            case (i_avs.address)
                OFS_DATA: rdata_d = rx_mem[rx_rp_q[3:0]];
                OFS_DIV_LO: rdata_d = div_lo_q;
                OFS_DIV_HI: rdata_d = div_hi_q;
                OFS_LINE_CTRL: rdata_d = lc_q;
                OFS_MODEM_CTRL: rdata_d = mc_q;
                OFS_LINE_STAT: rdata_d = ls_val;
                OFS_MODEM_STAT: rdata_d = {6'h00, ~filt_q[3], ~filt_q[2]};
                OFS_LP_DIV_LO: rdata_d = lpl_q;
                OFS_LP_DIV_HI: rdata_d = lph_q;
                default: rdata_d = 8'h00;
            endcase
        end
        div_lo_d = div_lo_q;
        div_hi_d = div_hi_q;
        lc_d = lc_q;
        mc_d = mc_q;
        lpl_d = lpl_q;
        lph_d = lph_q;
        settle_d = busy ? settle_q - 4'h1 : settle_q;
        if (wr) begin
            case (i_avs.address)
                OFS_DIV_LO: div_lo_d = i_avs.writedata[7:0];
                OFS_DIV_HI: div_hi_d = i_avs.writedata[7:0];
                OFS_LINE_CTRL: lc_d = i_avs.writedata[7:0];
                OFS_MODEM_CTRL: mc_d = i_avs.writedata[7:0];
                OFS_LP_DIV_LO: lpl_d = i_avs.writedata[7:0];
                OFS_LP_DIV_HI: lph_d = i_avs.writedata[7:0];
                default: ;
            endcase
            if (i_avs.address != OFS_DATA) begin
                settle_d = SETTLE_CYCLES;
            end
        end
        // Clear only what the read reported; a new set wins
        err_d = err_q;
        if (rd && i_avs.address == OFS_LINE_STAT) begin
            err_d = err_q & ~rdata_q;
        end
        if (rx_pop) begin
            err_d[LS_TIMEOUT] = 1'b0;
        end
        err_d[LS_OVERRUN] = err_d[LS_OVERRUN] | ovr_set;
        err_d[LS_PARITY] = err_d[LS_PARITY] | per_set;
        err_d[LS_FRAMING] = err_d[LS_FRAMING] | fer_set;
        err_d[LS_BREAK] = err_d[LS_BREAK] | brk_set;
        err_d[LS_TIMEOUT] = err_d[LS_TIMEOUT] | tmo_set;
        err_d = err_d & 8'h9E;
        rtsn_d = ~mc_d[MC_RTS];
        dtrn_d = ~mc_d[MC_DTR];
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 1'b1;
            rdata_q <= 8'h00;
            div_lo_q <= DIV_RST;
            div_hi_q <= DIV_RST;
            lc_q <= LINE_CTRL_RST;
            mc_q <= MODEM_CTRL_RST;
            lpl_q <= DIV_RST;
            lph_q <= DIV_RST;
            settle_q <= SETTLE_CYCLES;
            err_q <= 8'h00;
            rtsn_q <= 1'b1;
            dtrn_q <= 1'b1;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            div_lo_q <= div_lo_d;
            div_hi_q <= div_hi_d;
            lc_q <= lc_d;
            mc_q <= mc_d;
            lpl_q <= lpl_d;
            lph_q <= lph_d;
            settle_q <= settle_d;
            err_q <= err_d;
            rtsn_q <= rtsn_d;
            dtrn_q <= dtrn_d;
        end
    end

    // FIFO storage; a push to a full receive FIFO is dropped
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_wp_q <= 5'h00;
            tx_rp_q <= 5'h00;
            rx_wp_q <= 5'h00;
            rx_rp_q <= 5'h00;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_q[3:0]] <= i_avs.writedata[7:0];
                tx_wp_q <= tx_wp_q + 5'h01;
            end
            if (tx_pop) begin
                tx_rp_q <= tx_rp_q + 5'h01;
            end
            if (rx_push && !rx_full) begin
                rx_mem[rx_wp_q[3:0]] <= rx_sh_q >> (4'h8 - fmt.data_bits);
                rx_wp_q <= rx_wp_q + 5'h01;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + 5'h01;
            end
        end
    end

    always_comb begin
        bcnt_d = bcnt_q + 16'h0001;
        tick_d = 1'b0;
        if ({div_hi_q, div_lo_q} == 16'h0000) begin
            bcnt_d = 16'h0000;
        end else if (bcnt_q >= {div_hi_q, div_lo_q} - 16'h0001) begin
            bcnt_d = 16'h0000;
            tick_d = 1'b1;
        end
        lpcnt_d = lpcnt_q + 16'h0001;
        lptick_d = 1'b0;
        if ({lph_q, lpl_q} == 16'h0000) begin
            lpcnt_d = 16'h0000;
        end else if (lpcnt_q >= {lph_q, lpl_q} - 16'h0001) begin
            lpcnt_d = 16'h0000;
            lptick_d = 1'b1;
        end
        // Light pulses arrive low; one pulse stands for one zero bit
        hold_d = hold_q;
        if (hold_q != 6'h00 && tick_q) begin
            hold_d = hold_q - 6'h01;
        end
        // Reload on the last held tick, so back-to-back zeros leave no gap
        if ((hold_q == 6'h00 || (hold_q == 6'h01 && tick_q)) && ~filt_q[1]
            && (mc_q[MC_LOW_POWER] ? lptick_q : tick_q)) begin
            hold_d = BIT_TICKS;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bcnt_q <= 16'h0000;
            tick_q <= 1'b0;
            lpcnt_q <= 16'h0000;
            lptick_q <= 1'b0;
            baudn_q <= 1'b1;
            hold_q <= 6'h00;
        end else begin
            bcnt_q <= bcnt_d;
            tick_q <= tick_d;
            lpcnt_q <= lpcnt_d;
            lptick_q <= lptick_d;
            baudn_q <= ~tick_d;
            hold_q <= hold_d;
        end
    end

    // Start only on a baud tick, else the start bit loses part of a tick
    assign tx_go = tick_q && !busy && !tx_empty && (!mc_q[MC_AUTO_FLOW] || !filt_q[2]);
    assign tx_end = tick_q && tx_tick_q == BIT_TICKS - 6'h01;

    always_comb begin
        tx_st_d = tx_st_q;
        tx_tick_d = tick_q ? tx_tick_q + 6'h01 : tx_tick_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_x_d = tx_x_q;
        tx_pop = 1'b0;
        case (tx_st_q)
            ST_IDLE: begin
                tx_tick_d = 6'h00;
                if (tx_go) begin
                    tx_pop = 1'b1;
                    tx_sh_d = tx_mem[tx_rp_q[3:0]];
                    tx_x_d = 1'b0;
                    tx_st_d = ST_START;
                end
            end
            ST_START: begin
                if (tx_end) begin
                    tx_tick_d = 6'h00;
                    tx_bit_d = 3'h0;
                    tx_st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (tx_end) begin
                    tx_tick_d = 6'h00;
                    tx_x_d = tx_x_q ^ tx_sh_q[0];
                    tx_sh_d = {1'b0, tx_sh_q[7:1]};
                    tx_bit_d = tx_bit_q + 3'h1;
                    if ({1'b0, tx_bit_q} == fmt.data_bits - 4'h1) begin
                        tx_st_d = fmt.par_en ? ST_PAR : ST_STOP;
                    end
                end
            end
            ST_PAR: begin
                if (tx_end) begin
                    tx_tick_d = 6'h00;
                    tx_st_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (tick_q && tx_tick_q == fmt.stop_ticks - 6'h01) begin
                    tx_tick_d = 6'h00;
                    tx_st_d = ST_IDLE;
                end
            end
            default: tx_st_d = ST_IDLE;
        endcase
        if (busy) begin
            tx_st_d = ST_IDLE;
        end
        case (tx_st_q)
            ST_START: tx_lvl = 1'b0;
            ST_DATA: tx_lvl = tx_sh_q[0];
            ST_PAR: tx_lvl = tx_x_q ^ ~fmt.par_even;
            default: tx_lvl = 1'b1;
        endcase
        sout_d = ir_on | (tx_lvl & ~lc_q[LC_BREAK]);
        irn_d = ~(ir_on && !tx_lvl && tx_tick_q < IR_PULSE_TICKS);
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st_q <= ST_IDLE;
            tx_tick_q <= 6'h00;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_x_q <= 1'b0;
            sout_q <= 1'b1;
            irn_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_tick_q <= tx_tick_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_x_q <= tx_x_d;
            sout_q <= sout_d;
            irn_q <= irn_d;
        end
    end

    assign rx_in = ir_on ? hold_q == 6'h00 : filt_q[0];
    assign rx_samp = tick_q && rx_tick_q == BIT_TICKS - 6'h01;

    always_comb begin
        rx_st_d = rx_st_q;
        rx_tick_d = tick_q ? rx_tick_q + 6'h01 : rx_tick_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_x_d = rx_x_q;
        rx_zero_d = rx_zero_q;
        perr_d = perr_q;
        rx_push = 1'b0;
        per_set = 1'b0;
        fer_set = 1'b0;
        brk_set = 1'b0;
        case (rx_st_q)
            ST_IDLE: begin
                rx_tick_d = 6'h00;
                if (!rx_in) begin
                    rx_x_d = 1'b0;
                    rx_zero_d = 1'b1;
                    perr_d = 1'b0;
                    rx_st_d = ST_START;
                end
            end
            ST_START: begin
                if (tick_q && rx_tick_q == HALF_TICKS - 6'h01) begin
                    rx_tick_d = 6'h00;
                    rx_bit_d = 3'h0;
                    rx_st_d = rx_in ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (rx_samp) begin
                    rx_tick_d = 6'h00;
                    rx_sh_d = {rx_in, rx_sh_q[7:1]};
                    rx_x_d = rx_x_q ^ rx_in;
                    rx_zero_d = rx_zero_q & ~rx_in;
                    rx_bit_d = rx_bit_q + 3'h1;
                    if ({1'b0, rx_bit_q} == fmt.data_bits - 4'h1) begin
                        rx_st_d = fmt.par_en ? ST_PAR : ST_STOP;
                    end
                end
            end
            ST_PAR: begin
                if (rx_samp) begin
                    rx_tick_d = 6'h00;
                    perr_d = rx_x_q ^ rx_in ^ ~fmt.par_even;
                    rx_zero_d = rx_zero_q & ~rx_in;
                    rx_st_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (rx_samp) begin
                    rx_tick_d = 6'h00;
                    if (!rx_in && rx_zero_q) begin
                        brk_set = 1'b1;
                        rx_st_d = ST_BREAK;
                    end else begin
                        rx_push = 1'b1;
                        fer_set = ~rx_in;
                        per_set = perr_q;
                        rx_st_d = ST_IDLE;
                    end
                end
            end
            ST_BREAK: begin
                if (rx_in) begin
                    rx_st_d = ST_IDLE;
                end
            end
            default: rx_st_d = ST_IDLE;
        endcase
        if (busy) begin
            rx_st_d = ST_IDLE;
        end
        ovr_set = rx_push & rx_full;
        // Any push or pop restarts the idle count
        tmo_set = 1'b0;
        tmo_d = tmo_q;
        if (rx_empty || rx_push || rx_pop) begin
            tmo_d = 10'h000;
        end else if (tick_q && tmo_q != timeout_ticks(fmt)) begin
            tmo_d = tmo_q + 10'h001;
            tmo_set = tmo_d == timeout_ticks(fmt);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_st_q <= ST_IDLE;
            rx_tick_q <= 6'h00;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_x_q <= 1'b0;
            rx_zero_q <= 1'b0;
            perr_q <= 1'b0;
            tmo_q <= 10'h000;
        end else begin
            rx_st_q <= rx_st_d;
            rx_tick_q <= rx_tick_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_x_q <= rx_x_d;
            rx_zero_q <= rx_zero_d;
            perr_q <= perr_d;
            tmo_q <= tmo_d;
        end
    end

    AST_START_LOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (tx_st_q == ST_IDLE && tx_go && !ir_on && !lc_q[LC_BREAK]) |=> ##1 !o_serial_out)
        else $error("start bit not low");
    AST_BIT_TIME: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (tx_st_q == ST_START || tx_st_q == ST_DATA || tx_st_q == ST_PAR) |-> tx_tick_q < BIT_TICKS)
        else $error("bit tick counter overran");
    AST_STOP_LEN: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (tx_st_q == ST_STOP && tx_st_d == ST_IDLE && !busy) |-> tx_tick_q == fmt.stop_ticks - 6'h01)
        else $error("stop length wrong");
    AST_MID_DROP: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (rx_st_q == ST_START && rx_st_d == ST_IDLE && !busy) |-> rx_in && rx_tick_q == HALF_TICKS - 6'h01)
        else $error("start dropped off mid point");
    AST_IR_PULSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_ir_out_n |-> $past(ir_on) && $past(tx_tick_q) < IR_PULSE_TICKS)
        else $error("infrared pulse too wide");
    AST_SETTLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr && i_avs.address == OFS_LINE_CTRL) |=> ##1 (tx_st_q == ST_IDLE && rx_st_q == ST_IDLE) [*8])
        else $error("data moved during settle");
    AST_OVERRUN: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (rx_push && rx_full) |=> err_q[LS_OVERRUN] && rx_full)
        else $error("overrun not flagged");
    AST_BREAK_OUT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (lc_q[LC_BREAK] && !ir_on) |=> !o_serial_out)
        else $error("break not driven");
    AST_ACK: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((i_avs.read || i_avs.write) && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer timing wrong");
endmodule

// ### design/uart_pkg.sv
// Purpose: Shared constants and types of the serial port
// Assumes: Word-aligned byte offsets on the register bus
// Notes: One constant per number
package uart_pkg;
    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_DIV_LO = 6'h04;
    localparam logic [5:0] OFS_DIV_HI = 6'h08;
    localparam logic [5:0] OFS_LINE_CTRL = 6'h0C;
    localparam logic [5:0] OFS_MODEM_CTRL = 6'h10;
    localparam logic [5:0] OFS_LINE_STAT = 6'h14;
    localparam logic [5:0] OFS_MODEM_STAT = 6'h18;
    localparam logic [5:0] OFS_LP_DIV_LO = 6'h1C;
    localparam logic [5:0] OFS_LP_DIV_HI = 6'h20;
    localparam logic [7:0] LINE_CTRL_RST = 8'h03;
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam int LC_LEN = 0;
    localparam int LC_STOP = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_PAR_EVEN = 4;
    localparam int LC_BREAK = 6;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_AUTO_FLOW = 5;
    localparam int MC_IR = 6;
    localparam int MC_LOW_POWER = 7;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_TIMEOUT = 7;
    localparam bit IR_BUILD = 1'b1;
    localparam logic [5:0] BIT_TICKS = 6'h10;
    localparam logic [5:0] HALF_TICKS = 6'h08;
    localparam logic [5:0] IR_PULSE_TICKS = 6'h03;
    localparam logic [3:0] SETTLE_CYCLES = 4'h8;
    localparam logic [9:0] TIMEOUT_CHARS = 10'h004;
    localparam int FIFO_DEPTH = 16;

    typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_BREAK} frame_state_t;

    typedef struct packed {
        logic [3:0] data_bits;
        logic par_en;
        logic par_even;
        logic [5:0] stop_ticks;
    } frame_fmt_t;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_t;

    function automatic frame_fmt_t make_fmt(input logic [7:0] lc, input logic ir);
        frame_fmt_t f;
        f.data_bits = ir ? 4'h8 : 4'h5 + {2'b00, lc[LC_LEN +: 2]};
        f.par_en = ~ir & lc[LC_PAR_EN];
        f.par_even = lc[LC_PAR_EVEN];
        if (ir || !lc[LC_STOP]) begin
            f.stop_ticks = BIT_TICKS;
        end else if (lc[LC_LEN +: 2] == 2'b00) begin
            f.stop_ticks = BIT_TICKS + HALF_TICKS;
        end else begin
            f.stop_ticks = BIT_TICKS + BIT_TICKS;
        end
        return f;
    endfunction

    function automatic logic [9:0] timeout_ticks(input frame_fmt_t f);
        logic [9:0] bits;
        bits = 10'h001 + {6'h00, f.data_bits} + {9'h000, f.par_en};
        return 10'(TIMEOUT_CHARS * ((bits << 4) + {4'h0, f.stop_ticks}));
    endfunction

    function automatic logic fifo_full(input logic [4:0] w, input logic [4:0] r);
        return (w[4] != r[4]) && (w[3:0] == r[3:0]);
    endfunction
endpackage

// ### test/far_end.sv
// Purpose: Far-end model, a null-modem loop of all lines
// Assumes: Serial and infrared lines idle high
// Notes: Light pulses come back low, as a photo receiver gives them
`timescale 1ns/10ps
module far_end (
    input wire logic i_tx,
    input wire logic i_ir_tx_n,
    input wire logic i_rts_n,
    input wire logic i_dtr_n,
    output logic o_rx,
    output logic o_ir_rx,
    output logic o_cts_n,
    output logic o_dsr_n
);
    assign o_rx = i_tx;
    assign o_ir_rx = i_ir_tx_n;
    assign o_cts_n = i_rts_n;
    assign o_dsr_n = i_dtr_n;
endmodule

// ### test/async_serial_port_with_infrared_test.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Divisor 2, 28 in infrared mode; far end loops every line back
// Notes: Receive is polled through line status
`timescale 1ns/10ps
module async_serial_port_with_infrared_test;
    import uart_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    avs_req_t avs = '0;
    logic [31:0] rdata, rd_data;
    logic waitreq, sout, sin, ir_out_n, ir_in, cts_n, dsr_n, rts_n, dtr_n, baud_n;
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    logic [7:0] fmt [5] = '{8'h03, 8'h18, 8'h0D, 8'h1E, 8'h04};
    logic [7:0] dat [5] = '{8'hA5, 8'hF3, 8'hFF, 8'h55, 8'h0B};
    always #10 i_core_clk = ~i_core_clk;
    serial_port i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs(avs), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_serial_in(sin), .o_serial_out(sout), .i_ir_in(ir_in),
        .o_ir_out_n(ir_out_n), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
        .o_baud_out_n(baud_n));
    far_end i_far (.i_tx(sout), .i_ir_tx_n(ir_out_n), .i_rts_n(rts_n), .i_dtr_n(dtr_n), .o_rx(sin),
        .o_ir_rx(ir_in), .o_cts_n(cts_n), .o_dsr_n(dsr_n));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        avs <= '{a, ~wr, wr, {24'h0, d}, 4'hF};
        do begin
            @(posedge i_core_clk);
        end while (waitreq !== 1'b0);
        rd_data = rdata;
        avs <= '0;
        @(posedge i_core_clk);
    endtask
    task automatic rx_check(input logic [7:0] e);
        int t = 0;
        do begin
            bus(1'b0, OFS_LINE_STAT, 8'h00);
            t++;
        end while (rd_data[0] !== 1'b1 && t < 3000);
        check("rx ready", rd_data[0], 32'h1);
        check("rx err", rd_data[4:1], 32'h0);
        bus(1'b0, OFS_DATA, 8'h00);
        check("rx data", rd_data, {24'h0, e});
    endtask
    task automatic low_width(input logic ir, input int e);
        int w = 0;
        wait ((ir ? ir_out_n : sout) === 1'b0);
        while ((ir ? ir_out_n : sout) === 1'b0) begin
            @(posedge i_core_clk);
            #1 w++;
        end
        check("low width", w, e);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge i_core_clk);
        check("reset pins", {waitreq, sout, ir_out_n, rts_n, dtr_n, baud_n}, 32'h3F);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        bus(1'b1, OFS_MODEM_CTRL, 8'h03);
        repeat (8) @(posedge i_core_clk);
        bus(1'b0, OFS_MODEM_STAT, 8'h00);
        check("modem status", rd_data, 32'h3);
        bus(1'b0, 6'h3C, 8'h00);
        check("unmapped", rd_data, 32'h0);
        bus(1'b1, OFS_DIV_LO, 8'h02);
        n = 0;
        repeat (32) begin
            @(posedge i_core_clk);
            n += int'(baud_n === 1'b0);
        end
        check("baud ticks", n, 32'h10);
        // Odd data keeps the start bit apart from data bit zero
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFS_LINE_CTRL, fmt[i]);
            bus(1'b1, OFS_DATA, dat[i]);
            low_width(1'b0, 32);
            rx_check(dat[i] & (8'hFF >> (3 - fmt[i][1:0])));
        end
        bus(1'b1, OFS_MODEM_CTRL, 8'h43);
        // Infrared rate kept under its ceiling: 50 MHz / (16 * 28)
        bus(1'b1, OFS_DIV_LO, 8'h1C);
        // One character, nothing else moves until it is back
        bus(1'b1, OFS_DATA, 8'hC5);
        low_width(1'b1, 84);
        check("serial idle", sout, 32'h1);
        rx_check(8'hC5);
        bus(1'b1, OFS_MODEM_CTRL, 8'h00);
        bus(1'b1, OFS_DIV_LO, 8'h02);
        bus(1'b1, OFS_LINE_CTRL, 8'h43);
        repeat (400) @(posedge i_core_clk);
        check("break out", sout, 32'h0);
        bus(1'b1, OFS_LINE_CTRL, 8'h03);
        repeat (100) @(posedge i_core_clk);
        bus(1'b0, OFS_LINE_STAT, 8'h00);
        check("break seen", rd_data[4], 32'h1);
        test_done();
    end
endmodule
